// ### src/pms_pkg.sv
// constants, register map and encodings of the measurement sequencer
package pms_pkg;
  localparam int unsigned AW  = 8;  // apb address width
  localparam int unsigned DW  = 32; // apb data width
  localparam int unsigned SW  = 16; // detector sample width
  localparam int unsigned NCH = 3;  // channels per module
  // register byte offsets
  localparam logic [AW-1:0] A_CTRL  = 8'h00; // mode, feed, aux, quantity, run
  localparam logic [AW-1:0] A_TIME  = 8'h04; // phase length in cycles
  localparam logic [AW-1:0] A_PNTS  = 8'h08; // trace points
  localparam logic [AW-1:0] A_STAT  = 8'h0C; // sequencer state
  localparam logic [AW-1:0] A_CHSEL = 8'h10; // channel for result reads
  localparam logic [AW-1:0] A_RES   = 8'h14; // result of selected channel
  localparam logic [AW-1:0] A_RALL  = 8'h18; // all results, comma stream
  localparam logic [AW-1:0] A_AUXLO = 8'h1C; // min or random trace value
  localparam logic [AW-1:0] A_AUXHI = 8'h20; // max trace value
  localparam logic [AW-1:0] A_CAT   = 8'h24; // quantity catalog stream
  // control field positions
  localparam int unsigned C_RUN  = 0;  // run request
  localparam int unsigned C_TRC  = 1;  // 1: trace mode
  localparam int unsigned C_MOV  = 2;  // 1: moving termination
  localparam int unsigned C_FEED = 3;  // 2 bits
  localparam int unsigned C_AUX  = 5;  // 2 bits
  localparam int unsigned C_QTY  = 7;  // 3 bits
  localparam int unsigned C_AVG  = 10; // 3 bits, log2 of average count
  localparam int unsigned CW     = 13; // control width
  // status field positions
  localparam int unsigned S_CHOP = 2;
  localparam int unsigned S_SETL = 3;
  localparam int unsigned S_TERR = 4;
  localparam int unsigned S_CNT  = 8;  // 8 bits
  // reset values
  localparam logic [CW-1:0] CTRL_RST  = 13'h0000;
  localparam logic [SW-1:0] TIME_RST  = 16'h0064;
  localparam logic [SW-1:0] PNTS_RST  = 16'h000A;
  localparam logic [1:0]    CHSEL_RST = 2'h1;
  localparam logic [DW-1:0] SEP_WORD  = 32'h0000002C; // ascii comma
  // result feed
  localparam logic [1:0] F_AVG = 2'h0;
  localparam logic [1:0] F_PK  = 2'h1;
  localparam logic [1:0] F_RND = 2'h2;
  // aux_measure_select measurement
  localparam logic [1:0] X_NONE = 2'h0;
  localparam logic [1:0] X_MM   = 2'h1;
  localparam logic [1:0] X_RM   = 2'h2;
  // output quantities
  localparam logic [2:0] Q_ISO = 3'h0;
  localparam logic [2:0] Q_DEN = 3'h1;
  localparam logic [2:0] Q_EF  = 3'h2;
  localparam logic [2:0] Q_MF  = 3'h3;
  localparam logic [2:0] Q_DET = 3'h4;
  localparam logic [3:0] CAT_LAST = 4'h8; // stream words minus one
  localparam logic [2:0] RALL_LAST = 3'h4;
  localparam int unsigned Z0_MOHM = 376730; // free space, milliohm
  // random pick source
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_WAIT  = 2'b01,
    S_PHASE = 2'b11,
    S_DONE  = 2'b10
  } pms_state_e;
endpackage : pms_pkg

// ### src/pms_sequencer.sv
// power measurement sequencer with apb register slave
//
// The APB interface to the registers and the register addresses were decided locally.
module pms_sequencer (
  input  wire logic                   pclk,         // bus clock
  input  wire logic                   presetn,      // async reset
  input  wire logic [pms_pkg::AW-1:0] paddr,        // byte address
  input  wire logic                   psel,         // slave select
  input  wire logic                   penable,      // access phase
  input  wire logic                   pwrite,       // 1 write
  input  wire logic [pms_pkg::DW-1:0] pwdata,       // write data
  output logic      [pms_pkg::DW-1:0] prdata,       // read data
  output logic                        pready,       // access done
  output logic                        pslverr,      // unmapped
  input  wire logic                   trig,         // trigger pulse
  input  wire logic                   smp_vld,      // samples valid
  input  wire logic [pms_pkg::SW-1:0] smp_ch1,      // channel 1
  input  wire logic [pms_pkg::SW-1:0] smp_ch2,      // channel 2
  input  wire logic [pms_pkg::SW-1:0] smp_ch3,      // channel 3
  output logic                        trig_sync,    // phase active
  output logic                        chop_inv,     // detector invert
  output logic                        res_stb,      // new result
  output logic                        settled,      // result settled
  output logic      [2:0]             quantity_sel  // output quantity
);
  import pms_pkg::*;

  // registers
  logic [CW-1:0]    ctrl_r;   // control word
  logic [SW-1:0]    time_r;   // phase cycles
  logic [SW-1:0]    pnts_r;   // trace points
  logic [1:0]       chsel_r;  // selected channel
  logic [2:0]       rptr_r;   // all-result stream index
  logic [3:0]       cptr_r;   // catalog stream index
  pms_state_e       st_r;     // sequencer state
  pms_state_e       st_nxt;   // next state
  logic [SW-1:0]    tcnt_r;   // cycles in phase
  logic [SW:0]      pacc_r;   // point boundary accumulator
  logic [7:0]       n_r;      // completed measurements
  logic             chop_r;   // inverted phase
  logic             sync_r;   // sync output
  logic             stb_r;    // result strobe
  logic             setl_r;   // settled flag
  logic [15:0]      lfsr_r;   // random source
  logic [DW-1:0]    prdata_r; // read data
  logic             pready_r; // ready
  logic             pslverr_r;// error
  // control fields
  logic             run, trc, mov_req, mov, single;
  logic [1:0]       feed, aux;
  logic [2:0]       avg_k;
  logic [7:0]       avg_n;    // average count
  // sequencing terms
  logic [SW-1:0]    tlim;     // last cycle index of a phase
  logic             ph_end;   // phase finishes this cycle
  logic             ph_start; // phase begins next cycle
  logic             pt_end;   // trace point boundary
  logic [SW:0]      psum;     // point accumulator sum
  logic             last_n;   // repeat window complete
  logic             deliver;  // result leaves at done
  logic [7:0]       n_inc;    // measurement count plus one
  // bus terms
  logic             setup;    // setup cycle
  logic             acc;      // completing access
  logic             hit;      // mapped address
  logic [DW-1:0]    rdata;    // read mux
  // per channel results
  logic [DW-1:0]    res_w [NCH];
  logic [DW-1:0]    lo_w  [NCH];
  logic [DW-1:0]    hi_w  [NCH];
  logic [NCH*SW-1:0] smp_all;

  assign smp_all = {smp_ch3, smp_ch2, smp_ch1};
  assign run     = ctrl_r[C_RUN];
  assign trc     = ctrl_r[C_TRC];              // 0 continuous average
  assign mov_req = ctrl_r[C_MOV];
  assign feed    = ctrl_r[C_FEED +: 2];
  assign aux     = ctrl_r[C_AUX +: 2];
  assign avg_k   = ctrl_r[C_AVG +: 3];
  assign avg_n   = 8'h01 << avg_k;
  assign single  = (avg_k == 3'h0);            // termination ignored
  // trace mode forces repeating termination
  assign mov     = mov_req & ~trc & ~single;

  // outputs straight from flops
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign trig_sync    = sync_r;
  assign chop_inv     = chop_r;
  assign res_stb      = stb_r;
  assign settled      = setl_r;
  assign quantity_sel = ctrl_r[C_QTY +: 3];

  // sequencing decisions
  always_comb begin
    tlim    = (time_r == '0) ? '0 : time_r - 16'h0001;
    ph_end  = (st_r == S_PHASE) && (tcnt_r == tlim);
    psum    = pacc_r + {1'b0, pnts_r};
    // bresenham spread: points boundaries over time cycles
    pt_end  = (st_r == S_PHASE) && trc && (psum >= {1'b0, time_r});
    n_inc   = (n_r == 8'hFF) ? n_r : n_r + 8'h01;
    last_n  = (n_inc >= avg_n);
    deliver = single | mov | last_n;
    st_nxt  = st_r;
    case (st_r)
      S_IDLE: begin
        if (run) st_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (!run) st_nxt = S_IDLE;
        else if (trig) st_nxt = S_PHASE;
      end
      S_PHASE: begin
        if (ph_end) begin
          // cont mode chains the inverted phase without a trigger
          if (!chop_r && !single && !trc) st_nxt = S_PHASE;
          else if (!chop_r && !single) st_nxt = S_WAIT;
          else st_nxt = S_DONE;
        end
      end
      S_DONE: begin
        st_nxt = (single || !run) ? S_IDLE : S_WAIT;
      end
      default: st_nxt = S_IDLE;
    endcase
    ph_start = (st_r == S_WAIT) && (st_nxt == S_PHASE);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= S_IDLE;
    else st_r <= st_nxt;
  end

  // phase timer and point accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_r <= '0;
      pacc_r <= '0;
    end else if (st_r != S_PHASE || ph_end) begin
      tcnt_r <= '0;                            // exact trace time
      pacc_r <= '0;
    end else begin
      tcnt_r <= tcnt_r + 16'h0001;
      pacc_r <= pt_end ? psum - {1'b0, time_r} : psum;
    end
  end

  // chopper polarity and sync output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      // sync follows the next state so it spans the phase exactly
      sync_r <= (st_nxt == S_PHASE);
      if (st_r == S_DONE || st_r == S_IDLE) chop_r <= 1'b0;
      else if (ph_end && !single) chop_r <= 1'b1;
    end
  end

  // measurement counter, strobe and settled flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_r    <= '0;
      stb_r  <= 1'b0;
      setl_r <= 1'b0;
    end else begin
      stb_r <= (st_r == S_DONE) && deliver;
      if (st_r == S_IDLE && run) begin
        n_r <= '0;
      end else if (st_r == S_DONE) begin
        // repeat restarts the window, moving keeps counting
        n_r <= (mov) ? n_inc : (deliver ? 8'h00 : n_inc);
        if (deliver) setl_r <= single | last_n;
      end
    end
  end

  // random source, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr_r <= LFSR_SEED;
    else lfsr_r <= (lfsr_r >> 1) ^ (lfsr_r[0] ? LFSR_TAPS : 16'h0000);
  end

  // per channel datapath
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [SW-1:0]        s;       // this channel's sample
    logic signed [DW-1:0] sv;      // sample as signed word
    logic signed [DW-1:0] acc_r;   // chopped sum
    logic signed [DW-1:0] avg_r;   // window sum or moving value
    logic signed [DW-1:0] avg_o;   // result of averaging
    logic [DW-1:0]        res_r;   // delivered result
    logic [DW-1:0]        lo_r;    // min or random
    logic [DW-1:0]        hi_r;    // max
    logic [SW-1:0]        pk_r, mn_r, rn_r;    // running trackers
    logic [SW-1:0]        ppk_r, pmn_r, prn_r; // last trace point
    logic                 first_r; // tracker empty
    logic                 take, trk, clr, fresh;

    assign s  = smp_all[c*SW +: SW];
    assign sv = signed'({{(DW-SW){1'b0}}, s});
    // no accumulation outside a phase
    assign take  = (st_r == S_PHASE) && smp_vld;
    assign trk   = take && !chop_r;
    assign clr   = (ph_start && !chop_r) || pt_end;
    assign fresh = first_r || clr;

    // averaging of the measurement values
    always_comb begin
      if (mov && n_r != 8'h00) avg_o = avg_r + ((acc_r - avg_r) >>> avg_k);
      else if (mov) avg_o = acc_r;
      else avg_o = (avg_r + acc_r) >>> avg_k;
    end

    // chopped accumulation: add then subtract
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) acc_r <= '0;
      else if (st_r == S_DONE) acc_r <= '0;
      else if (take) acc_r <= chop_r ? acc_r - sv : acc_r + sv;
    end

    // window sum or moving value
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) avg_r <= '0;
      else if (st_r == S_IDLE) avg_r <= '0;
      else if (st_r == S_DONE) begin
        if (mov) avg_r <= avg_o;
        else avg_r <= deliver ? '0 : avg_r + acc_r;
      end
    end

    // peak, min and random trackers over noninverted samples
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        first_r <= 1'b1;
        pk_r    <= '0;
        mn_r    <= '0;
        rn_r    <= '0;
      end else if (trk) begin
        first_r <= 1'b0;
        if (fresh || s > pk_r) pk_r <= s;
        if (fresh || s < mn_r) mn_r <= s;
        // random pick always lies within min and max
        if (fresh || lfsr_r[2:0] == 3'h0) rn_r <= s;
      end else if (clr) begin
        first_r <= 1'b1;
      end
    end

    // per point capture in trace mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ppk_r <= '0;
        pmn_r <= '0;
        prn_r <= '0;
      end else if (pt_end) begin
        ppk_r <= pk_r;
        pmn_r <= mn_r;
        prn_r <= rn_r;
      end
    end

    // result and aux_measure_select capture at delivery
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        res_r <= '0;
        lo_r  <= '0;
        hi_r  <= '0;
      end else if (st_r == S_DONE && deliver) begin
        case (feed)
          F_PK:    res_r <= {16'h0000, trc ? ppk_r : pk_r};
          F_RND:   res_r <= {16'h0000, trc ? prn_r : rn_r};
          default: res_r <= avg_o;
        endcase
        case (aux)
          X_MM:    lo_r <= {16'h0000, trc ? pmn_r : mn_r};
          X_RM:    lo_r <= {16'h0000, trc ? prn_r : rn_r};
          default: lo_r <= '0;
        endcase
        hi_r <= (aux == X_NONE) ? '0 : {16'h0000, trc ? ppk_r : pk_r};
      end
    end

    assign res_w[c] = res_r;
    assign lo_w[c]  = lo_r;
    assign hi_w[c]  = hi_r;
  end

  // apb phases
  assign setup = psel && !penable;
  assign acc   = psel && penable && pready_r;

  // read mux and decode
  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    case (paddr)
      A_CTRL:  rdata = {{(DW-CW){1'b0}}, ctrl_r};
      A_TIME:  rdata = {16'h0000, time_r};
      A_PNTS:  rdata = {16'h0000, pnts_r};
      A_STAT:  rdata = {16'h0000, n_r, 3'h0, trc & mov_req, setl_r, chop_r, st_r};
      A_CHSEL: rdata = {30'h0, chsel_r};
      A_RES:   rdata = res_w[chsel_r - 2'h1];
      A_AUXLO: rdata = lo_w[chsel_r - 2'h1];
      A_AUXHI: rdata = hi_w[chsel_r - 2'h1];
      // results interleaved with commas
      A_RALL:  rdata = rptr_r[0] ? SEP_WORD : res_w[rptr_r[2:1]];
      // quantity codes interleaved with commas
      A_CAT:   rdata = cptr_r[0] ? SEP_WORD : {29'h0, cptr_r[3:1]};
      default: hit = 1'b0;
    endcase
  end

  // answer: ready one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup && !pwrite) ? rdata : '0;
      pslverr_r <= setup && !hit;
    end
  end

  // control register; software write wins over the hardware stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= CTRL_RST;
    else if (acc && pwrite && paddr == A_CTRL) ctrl_r <= pwdata[CW-1:0];
    else if (st_r == S_DONE && single) ctrl_r[C_RUN] <= 1'b0;
  end

  // timing and channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_r  <= TIME_RST;
      pnts_r  <= PNTS_RST;
      chsel_r <= CHSEL_RST;
    end else if (acc && pwrite) begin
      if (paddr == A_TIME) time_r <= pwdata[SW-1:0];
      if (paddr == A_PNTS) pnts_r <= pwdata[SW-1:0];
      // only channels 1..3 are accepted
      if (paddr == A_CHSEL && pwdata[1:0] != 2'h0) chsel_r <= pwdata[1:0];
    end
  end

  // each stream pointer advances on a completed read of its own address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_r <= '0;
      cptr_r <= '0;
    end else if (acc && !pwrite) begin
      if (paddr == A_RALL) rptr_r <= (rptr_r == RALL_LAST) ? 3'h0 : rptr_r + 3'h1;
      if (paddr == A_CAT) cptr_r <= (cptr_r == CAT_LAST) ? 4'h0 : cptr_r + 4'h1;
    end
  end
endmodule : pms_sequencer

// ### tb/pms_src_model.sv
// trigger and detector sample source facing the sequencer
module pms_src_model (
  input  wire logic                   pclk,     // bus clock
  input  wire logic                   fire,     // bench asks for a trigger
  input  wire logic                   chop_inv, // detector polarity
  output logic                        trig,     // one-cycle trigger
  output logic                        smp_vld,  // sample strobe
  output logic      [pms_pkg::SW-1:0] smp_ch1,  // channel 1
  output logic      [pms_pkg::SW-1:0] smp_ch2,  // channel 2
  output logic      [pms_pkg::SW-1:0] smp_ch3   // channel 3
);
  timeunit 1ns;
  timeprecision 1ps;
  initial trig = 1'b0;
  // registered, so trig repeats fire one edge later and lasts as long as fire
  always @(posedge pclk) begin
    trig <= fire;
  end
  // a fixed offset shows in both phases and must cancel out
  always_comb begin
    smp_vld = 1'b1;
    smp_ch1 = chop_inv ? 16'h0020 : 16'h0120;
    smp_ch2 = chop_inv ? 16'h0020 : 16'h0220;
    smp_ch3 = chop_inv ? 16'h0020 : 16'h0320;
  end
endmodule : pms_src_model

// ### tb/pms_sequencer_sva.sv
// assertions on the sequencer ports
module pms_sequencer_sva
  import pms_pkg::*;
(
  input wire logic          pclk,        // bus clock
  input wire logic          presetn,     // async reset
  input wire logic [AW-1:0] paddr,       // byte address
  input wire logic          psel,        // select
  input wire logic          penable,     // access phase
  input wire logic          pwrite,      // write
  input wire logic [DW-1:0] pwdata,      // write data
  input wire logic          pready,      // access done
  input wire logic          trig,        // trigger
  input wire logic          trig_sync,   // phase active
  input wire logic          chop_inv,    // inverted phase
  input wire logic          res_stb,     // new result
  input wire logic          settled,     // settled flag
  input wire logic [2:0]    quantity_sel // quantity
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic          wr;      // completed write
  logic [SW-1:0] time_r;  // shadow phase length
  logic          trc_r;   // shadow trace mode
  logic [2:0]    avg_r;   // shadow log2 count
  logic [16:0]   len_r;   // high cycles of sync
  logic [SW-1:0] tm;      // zero length acts as one
  logic [16:0]   exp_len; // expected sync run
  assign wr = psel && penable && pready && pwrite;
  assign tm = (time_r == '0) ? 16'h0001 : time_r;
  // single phase or trace phase, else both phases back to back
  assign exp_len = (trc_r || avg_r == 3'h0) ? {1'b0, tm} : {tm, 1'b0};
  // shadows follow completed writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_r <= TIME_RST;
      trc_r  <= 1'b0;
      avg_r  <= 3'h0;
    end else if (wr && paddr == A_TIME) begin
      time_r <= pwdata[SW-1:0];
    end else if (wr && paddr == A_CTRL) begin
      trc_r <= pwdata[C_TRC];
      avg_r <= pwdata[C_AVG+:3];
    end
  end
  // length of the current high run of sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= '0;
    end else begin
      len_r <= trig_sync ? len_r + 17'h1 : 17'h0;
    end
  end
  property p_sync_start;
    $rose(trig_sync) |-> $past(trig);
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync rose without trigger");
  property p_phase_len;
    $fell(trig_sync) |-> len_r == exp_len;
  endproperty
  a_phase_len: assert property (p_phase_len)
    else $error("phase length wrong");
  property p_inv_rise;
    $rose(chop_inv) |-> $past(trig_sync);
  endproperty
  a_inv_rise: assert property (p_inv_rise)
    else $error("inverted polarity not set at a phase end");
  property p_noninv_first;
    $rose(trig_sync) && !trc_r |-> !chop_inv;
  endproperty
  a_noninv_first: assert property (p_noninv_first)
    else $error("measurement began inverted");
  property p_res_after;
    res_stb |-> !trig_sync && !$past(trig_sync) && $past(trig_sync, 2);
  endproperty
  a_res_after: assert property (p_res_after)
    else $error("result not after phase end");
  property p_res_pulse;
    res_stb |=> !res_stb;
  endproperty
  a_res_pulse: assert property (p_res_pulse)
    else $error("result strobe too long");
  property p_settle;
    $changed(settled) |-> res_stb || $past(res_stb);
  endproperty
  a_settle: assert property (p_settle)
    else $error("settled moved without a result");
  property p_qty;
    wr && paddr == A_CTRL |=> quantity_sel == $past(pwdata[C_QTY+:3]);
  endproperty
  a_qty: assert property (p_qty)
    else $error("quantity not taken from write");
endmodule : pms_sequencer_sva

bind pms_sequencer pms_sequencer_sva pms_sequencer_sva_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .trig(trig), .trig_sync(trig_sync), .chop_inv(chop_inv),
  .res_stb(res_stb), .settled(settled), .quantity_sel(quantity_sel)
);

// ### tb/test_power_measurement_sequencer.sv
// self-checking bench for the measurement sequencer
module test_power_measurement_sequencer;
  import pms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          pclk = 1'b0;    // bus clock
  logic          presetn = 1'b0; // async reset
  logic [AW-1:0] paddr = '0;     // byte address
  logic          psel = 1'b0;    // select
  logic          penable = 1'b0; // access phase
  logic          pwrite = 1'b0;  // direction
  logic [DW-1:0] pwdata = '0;    // write data
  logic [DW-1:0] prdata;         // read data
  logic          pready;         // access done
  logic          pslverr;        // unmapped
  logic          fire = 1'b0;    // trigger request
  logic          trig, smp_vld, trig_sync, chop_inv, res_stb, settled;
  logic [SW-1:0] smp_ch1, smp_ch2, smp_ch3;
  logic [2:0]    quantity_sel;   // quantity
  logic [DW-1:0] d;              // last read word
  logic          e, seen, st;    // error, result seen, settled
  int            n_fail = 0;     // mismatches
  int            n_compared = 0; // comparisons
  always #5 pclk = ~pclk;
  pms_sequencer pms_sequencer_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig),
    .smp_vld(smp_vld), .smp_ch1(smp_ch1), .smp_ch2(smp_ch2), .smp_ch3(smp_ch3),
    .trig_sync(trig_sync), .chop_inv(chop_inv), .res_stb(res_stb),
    .settled(settled), .quantity_sel(quantity_sel));
  pms_src_model pms_src_model_i (.pclk(pclk), .fire(fire), .chop_inv(chop_inv),
    .trig(trig), .smp_vld(smp_vld), .smp_ch1(smp_ch1), .smp_ch2(smp_ch2),
    .smp_ch3(smp_ch3));
  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [DW-1:0] ex, input logic [DW-1:0] got);
    n_compared++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // one apb transfer; read word and error land in d and e
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] wd);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      give_verdict();
    end
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // trigger only once the sequencer reports that it waits
  task automatic fire_n(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        apb(1'b0, A_STAT, '0);
        k++;
      end while (d[1:0] !== 2'b01 && k < 50);
      if (k >= 50) begin
        n_fail++;
        give_verdict();
      end
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
    end
  endtask : fire_n
  // watch a fixed window for a result strobe
  task automatic wait_res();
    seen = 1'b0;
    st   = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      if (res_stb === 1'b1 && !seen) begin
        seen = 1'b1;
        st   = settled;
      end
    end
  endtask : wait_res
  // fresh reset, short phases, then the control word
  task automatic start(input logic [DW-1:0] c);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_TIME, 32'h4);
    apb(1'b1, A_PNTS, 32'h2);
    apb(1'b1, A_CTRL, c);
  endtask : start
  task automatic t_defaults();
    apb(1'b0, A_CTRL, '0);
    chk("ctrl", 32'h0, d);
    apb(1'b0, A_TIME, '0);
    chk("time", 32'h64, d);
    apb(1'b0, A_PNTS, '0);
    chk("points", 32'hA, d);
    chk("quantity", 32'h0, {29'h0, quantity_sel});
    apb(1'b0, 8'h40, '0);
    chk("unmapped", 32'h1, {d[30:0], e});
  endtask : t_defaults
  // count one with moving asked: single phase, settled, back to idle
  task automatic t_single();
    int ch;
    start(32'h5);
    fire_n(1);
    wait_res();
    chk("single", 32'h3, {30'h0, seen, st});
    apb(1'b0, A_STAT, '0);
    chk("idle", 32'h0, {30'h0, d[1:0]});
    for (ch = 1; ch <= 3; ch++) begin
      apb(1'b1, A_CHSEL, 32'(ch));
      apb(1'b0, A_RES, '0);
      chk("channel", 32'((ch * 256 + 32) * 4), d);
    end
    apb(1'b1, A_CHSEL, 32'h0);
    apb(1'b0, A_CHSEL, '0);
    chk("chsel zero", 32'h3, d);
    apb(1'b0, A_AUXHI, '0);
    chk("aux none", 32'h0, d);
    for (ch = 0; ch < 5; ch++) begin
      apb(1'b0, A_RALL, '0);
      chk("all", ch[0] ? SEP_WORD : 32'(((ch / 2 + 1) * 256 + 32) * 4), d);
    end
  endtask : t_single
  // repeat, count two: nothing after one measurement
  task automatic t_repeat();
    start(32'h1 | (32'h1 << C_AVG));
    fire_n(1);
    wait_res();
    chk("early", 32'h0, {31'h0, seen});
    fire_n(1);
    wait_res();
    chk("repeat", 32'h3, {30'h0, seen, st});
    apb(1'b0, A_RES, '0);
    chk("difference", 32'h400, d);
  endtask : t_repeat
  // trace asks for moving but must still repeat over four phases
  task automatic t_trace();
    start(32'h7 | (32'h1 << C_AVG) | (32'(F_PK) << C_FEED));
    // a moving window would answer after this first measurement
    fire_n(2);
    wait_res();
    chk("trace first", 32'h0, {31'h0, seen});
    fire_n(1);
    wait_res();
    chk("trace early", 32'h0, {31'h0, seen});
    fire_n(1);
    wait_res();
    chk("trace", 32'h3, {30'h0, seen, st});
    apb(1'b0, A_STAT, '0);
    chk("trace error", 32'h1, {31'h0, d[S_TERR]});
    apb(1'b0, A_RES, '0);
    chk("point peak", 32'h120, d);
  endtask : t_trace
  task automatic t_moving();
    start(32'h5 | (32'h1 << C_AVG));
    fire_n(1);
    wait_res();
    chk("moving first", 32'h2, {30'h0, seen, st});
    fire_n(1);
    wait_res();
    chk("moving second", 32'h3, {30'h0, seen, st});
  endtask : t_moving
  // constant samples: peak, random, min and max agree
  task automatic t_feed();
    int i;
    for (i = 1; i <= 2; i++) begin
      start(32'h1 | (32'(i) << C_FEED) | (32'(i) << C_AUX));
      fire_n(1);
      wait_res();
      apb(1'b0, A_RES, '0);
      chk("feed", 32'h120, d);
      apb(1'b0, A_AUXLO, '0);
      chk("aux low", 32'h120, d);
      apb(1'b0, A_AUXHI, '0);
      chk("aux high", 32'h120, d);
    end
  endtask : t_feed
  task automatic t_qty();
    int q;
    for (q = 0; q < 5; q++) begin
      apb(1'b1, A_CTRL, 32'(q) << C_QTY);
      #1;
      chk("quantity", 32'(q), {29'h0, quantity_sel});
    end
    for (q = 0; q < 9; q++) begin
      apb(1'b0, A_CAT, '0);
      chk("catalog", q[0] ? SEP_WORD : 32'(q / 2), d);
    end
  endtask : t_qty
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_single();
    t_repeat();
    t_trace();
    t_moving();
    t_feed();
    t_qty();
    give_verdict();
  end
endmodule : test_power_measurement_sequencer
